// ---- prr_host_model.sv ----
// two-wire host model that reads and writes the readout's registers
`timescale 1ns/10ps
module prr_host_model #(
  parameter logic [6:0] ADDR = 7'h29 // device bus address
) (
  input  wire logic i_clock,   // core clock paces the bus phases
  input  wire logic i_sda,     // resolved data wire level
  output logic      o_scl,     // serial clock, idles high
  output logic      o_sda_low, // high while pulling data low
  output logic      o_between, // high from the end of the first byte of a pair read until the second byte is read
  output logic      o_nak      // sticky: some byte went unacked
);
  // six clocks a phase stays clear of the four-clock minimum and sync lag
  localparam int PH = 6;
  logic b;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_between = 1'b0;
    o_nak = 1'b0;
  end
  // pins move only just after a clock edge
  task automatic hold();
    repeat (PH) @(posedge i_clock);
    #1;
  endtask
  // data changes only while the clock is low
  task automatic put(input logic v);
    o_sda_low = ~v;
    hold();
    o_scl = 1'b1;
    hold();
    o_scl = 1'b0;
    hold();
  endtask
  // released wire floats to the pull-up level
  task automatic get(output logic v);
    o_sda_low = 1'b0;
    hold();
    o_scl = 1'b1;
    hold();
    v = i_sda;
    o_scl = 1'b0;
    hold();
  endtask
  // start, or repeated start when the clock is already low
  task automatic start();
    o_sda_low = 1'b0;
    hold();
    o_scl = 1'b1;
    hold();
    o_sda_low = 1'b1;
    hold();
    o_scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hold();
    o_scl = 1'b1;
    hold();
    o_sda_low = 1'b0;
    hold();
  endtask
  task automatic wbyte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    if (b) o_nak = 1'b1;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
  task automatic write_cmd(input logic [7:0] cmd, input logic [7:0] data, input logic wd);
    start();
    wbyte({ADDR, 1'b0});
    wbyte(cmd);
    if (wd) wbyte(data);
    stop();
  endtask
  // pair fetched in one auto-increment transfer from the low byte
  task automatic read_regs(input logic [7:0] cmd, input logic two,
                           output logic [7:0] d0, output logic [7:0] d1);
    d1 = 8'h00;
    start();
    wbyte({ADDR, 1'b0});
    wbyte(cmd);
    start();
    wbyte({ADDR, 1'b1});
    rbyte(~two, d0);
    if (two) o_between = 1'b1;
    if (two) rbyte(1'b1, d1);
    o_between = 1'b0;
    stop();
  endtask
endmodule // prr_host_model

// ---- prr_pkg.sv ----
// constants, carrier struct and state type for the proximity result readout
package prr_pkg;
  // register pointer values (5-bit command address field)
  localparam logic [4:0] ADDR_STATUS    = 5'h13;
  localparam logic [4:0] ADDR_RES_LOW   = 5'h18;
  localparam logic [4:0] ADDR_RES_HIGH  = 5'h19;
  localparam logic [4:0] ADDR_CLR_IRQ   = 5'h05;
  // status layout
  localparam int         STATUS_IRQ_BIT = 5;
  // command byte layout
  localparam int         CMD_SEL_BIT    = 7;
  localparam int         CMD_TYPE_HI    = 6;
  localparam int         CMD_TYPE_LO    = 5;
  localparam int         CMD_ADDR_HI    = 4;
  localparam logic [1:0] TYPE_AUTO_INC  = 2'h1;
  localparam logic [1:0] TYPE_SPECIAL   = 2'h3;
  // arbitrary default bus address
  localparam logic [6:0] DEV_ADDR_DEF   = 7'h29;
  // reset values and counts
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [4:0] RST_PTR        = 5'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [3:0] PERS_NONE      = 4'h0;
  localparam logic [3:0] PERS_MAX       = 4'hf;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  typedef struct packed {
    logic [7:0] high_threshold_msb;
    logic [7:0] high_threshold_lsb;
    logic [7:0] low_threshold_msb;
    logic [7:0] low_threshold_lsb;
    logic [3:0] interrupt_persistence_count;
  } prr_cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
  } prr_state_e;
endpackage

// ---- prr_readout.sv ----
// proximity result readout: serial slave, status, result pair with shadow byte
`timescale 1ns/10ps
module prr_readout
#(
  parameter logic [6:0] DEV_ADDR = prr_pkg::DEV_ADDR_DEF // arbitrary address
) (
  input  wire logic              i_clock,      // 40 MHz core clock
  input  wire logic              i_sys_rst,    // async reset, active high
  input  wire logic              i_scl,        // serial clock pin
  input  wire logic              i_sda,        // serial data pin level
  output logic                   o_sda_out,    // serial data drive value
  output logic                   o_sda_oe,     // high while pulling data low
  input  wire logic [15:0]       i_adc_result, // conversion result
  input  wire logic              i_adc_done,   // end of conversion pulse
  input  wire prr_pkg::prr_cfg_s i_cfg,        // thresholds and persistence
  output logic                   o_prox_irq    // proximity interrupt level
);
  import prr_pkg::*;

  logic [1:0]  scl_sync, sda_sync;
  logic        scl_d, sda_d;
  prr_state_e  state_reg;
  logic [2:0]  cnt_reg;
  logic        full_reg;
  logic [7:0]  shift_reg, tx_reg;
  logic        oe_reg, sda_out_reg;
  logic        rw_reg, mack_reg;
  logic [4:0]  ptr_reg;
  logic [1:0]  type_reg;
  logic [15:0] result_reg;
  logic [7:0]  shadow_reg;
  logic [3:0]  pers_cnt_reg;
  logic        proximity_irq_flag;

  // read mux: low byte live, high byte from shadow
  function automatic logic [7:0] rd_byte(input logic [4:0] ptr, input logic irq,
                                         input logic [15:0] res, input logic [7:0] shd);
    logic [7:0] v;
    v = RST_BYTE;
    v[STATUS_IRQ_BIT] = irq & (ptr == ADDR_STATUS);
    if (ptr == ADDR_RES_LOW)
      v = res[7:0];
    if (ptr == ADDR_RES_HIGH)
      v = shd;
    return v;
  endfunction

  // pins are asynchronous: two flops, then an edge-detect stage
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  // bus events
  wire scl_rise  = scl_sync[1] & ~scl_d;
  wire scl_fall  = ~scl_sync[1] & scl_d;
  wire bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire bus_stop  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // byte loads and command decode
  wire       tx_load  = scl_fall & ((state_reg == ST_ACK_ADDR & rw_reg) |
                                    (state_reg == ST_RACK & mack_reg));
  wire [7:0] tx_byte  = rd_byte(ptr_reg, proximity_irq_flag, result_reg, shadow_reg);
  wire       cmd_take = scl_fall & (state_reg == ST_CMD) & full_reg & shift_reg[CMD_SEL_BIT];
  wire [1:0] cmd_type = shift_reg[CMD_TYPE_HI:CMD_TYPE_LO];
  wire [4:0] cmd_addr = shift_reg[CMD_ADDR_HI:0];
  wire       wr_take  = scl_fall & (state_reg == ST_WDATA) & full_reg;
  wire       irq_clr  = cmd_take & (cmd_type == TYPE_SPECIAL) & (cmd_addr == ADDR_CLR_IRQ);
  wire       low_read = tx_load & (ptr_reg == ADDR_RES_LOW);

  // slave sequencer; a start or stop always releases the data line
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 3'h0;
      full_reg    <= 1'b0;
      shift_reg   <= RST_BYTE;
      tx_reg      <= RST_BYTE;
      oe_reg      <= 1'b0;
      rw_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      sda_out_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= ST_ADDR;
      cnt_reg   <= 3'h0;
      full_reg  <= 1'b0;
      oe_reg    <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_reg <= ST_IDLE;
      oe_reg    <= 1'b0;
    end
    else
    begin
      if (scl_rise)
      begin
        shift_reg <= {shift_reg[6:0], sda_sync[1]};
        cnt_reg   <= cnt_reg + 3'h1;
        if (cnt_reg == BIT_LAST)
          full_reg <= 1'b1;
        if (state_reg == ST_RACK)
          mack_reg <= ~sda_sync[1];
      end
      if (scl_fall)
      begin
        unique case (state_reg)
          ST_IDLE: ;
          ST_ADDR:
            if (full_reg)
            begin
              full_reg <= 1'b0;
              if (shift_reg[7:1] == DEV_ADDR)
              begin
                state_reg <= ST_ACK_ADDR;
                oe_reg    <= 1'b1;
                rw_reg    <= shift_reg[0];
              end
              else
                state_reg <= ST_IDLE;
            end
          ST_ACK_ADDR:
          begin
            cnt_reg <= 3'h0;
            if (rw_reg)
            begin
              state_reg <= ST_RDATA;
              tx_reg    <= tx_byte;
              oe_reg    <= ~tx_byte[7];
            end
            else
            begin
              state_reg <= ST_CMD;
              oe_reg    <= 1'b0;
            end
          end
          ST_CMD, ST_WDATA:
            if (full_reg)
            begin
              full_reg  <= 1'b0;
              state_reg <= (state_reg == ST_CMD) ? ST_ACK_CMD : ST_ACK_W;
              oe_reg    <= 1'b1;
            end
          ST_ACK_CMD, ST_ACK_W:
          begin
            // writes dropped: data bytes are acked, nothing here is writable
            cnt_reg   <= 3'h0;
            state_reg <= ST_WDATA;
            oe_reg    <= 1'b0;
          end
          ST_RDATA:
            if (full_reg)
            begin
              full_reg  <= 1'b0;
              state_reg <= ST_RACK;
              oe_reg    <= 1'b0;
            end
            else
              oe_reg <= ~tx_reg[BIT_LAST - cnt_reg];
          ST_RACK:
          begin
            cnt_reg <= 3'h0;
            if (mack_reg)
            begin
              state_reg <= ST_RDATA;
              tx_reg    <= tx_byte;
              oe_reg    <= ~tx_byte[7];
            end
            else
              state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // pointer: set by command, stepped after each byte in auto-increment mode
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ptr_reg  <= RST_PTR;
      type_reg <= 2'h0;
    end
    else if (cmd_take)
    begin
      ptr_reg  <= cmd_addr;
      type_reg <= cmd_type;
    end
    else if ((tx_load | wr_take) & (type_reg == TYPE_AUTO_INC))
      ptr_reg <= ptr_reg + 5'h1;
  end

  // range test and persistence count
  wire [15:0] low_thr  = {i_cfg.low_threshold_msb, i_cfg.low_threshold_lsb};
  wire [15:0] high_thr = {i_cfg.high_threshold_msb, i_cfg.high_threshold_lsb};
  wire        oor      = (i_adc_result < low_thr) | (i_adc_result > high_thr);
  wire [3:0]  pers_inc = (pers_cnt_reg == PERS_MAX) ? PERS_MAX : pers_cnt_reg + 4'h1;
  wire        irq_set  = i_adc_done & ((i_cfg.interrupt_persistence_count == PERS_NONE) |
                         (oor & (pers_inc >= i_cfg.interrupt_persistence_count)));

  // result, interrupt flag; a new event beats a same-cycle clear
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      result_reg         <= RST_WORD;
      pers_cnt_reg       <= PERS_NONE;
      proximity_irq_flag <= 1'b0;
    end
    else
    begin
      if (i_adc_done)
      begin
        result_reg   <= i_adc_result;
        pers_cnt_reg <= oor ? pers_inc : PERS_NONE;
      end
      proximity_irq_flag <= irq_set | (proximity_irq_flag & ~irq_clr);
    end
  end

  // shadow captured only on low-byte load
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      shadow_reg <= RST_BYTE;
    else if (low_read)
      shadow_reg <= result_reg[15:8];
  end

  // outputs straight from flops
  assign o_sda_oe   = oe_reg;
  assign o_sda_out  = sda_out_reg;
  assign o_prox_irq = proximity_irq_flag;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  AST_STATUS_RO: assert property (wr_take && !i_adc_done |=> $stable(proximity_irq_flag))
    else $error("write phase altered status content");
  AST_STATUS_BIT: assert property (tx_load && ptr_reg == ADDR_STATUS |=>
    tx_reg == {2'h0, $past(proximity_irq_flag), 5'h00})
    else $error("status byte wrong");
  AST_RESULT_UPD: assert property (i_adc_done |=> result_reg == $past(i_adc_result))
    else $error("result not updated");
  AST_LOW_BYTE: assert property (low_read |=> tx_reg == $past(result_reg[7:0]))
    else $error("low byte wrong");
  AST_SHADOW_CAP: assert property (low_read |=> shadow_reg == $past(result_reg[15:8]))
    else $error("shadow not captured");
  AST_HIGH_BYTE: assert property (tx_load && ptr_reg == ADDR_RES_HIGH |=>
    tx_reg == $past(shadow_reg))
    else $error("high byte not from shadow");
  AST_IRQ_EVERY: assert property (i_adc_done &&
    i_cfg.interrupt_persistence_count == PERS_NONE |=> proximity_irq_flag)
    else $error("interrupt missed");
  AST_PERSIST: assert property (i_adc_done && !oor |=> pers_cnt_reg == PERS_NONE)
    else $error("persistence count not cleared");
  AST_SHADOW_HOLD: assert property (!low_read |=> $stable(shadow_reg))
    else $error("shadow changed without low read");

  COV_PAIR_READ: cover property (low_read ##[1:1000] (tx_load && ptr_reg == ADDR_RES_HIGH));
  COV_IRQ_RISE: cover property ($rose(proximity_irq_flag));
  COV_IRQ_CLR: cover property (irq_clr && proximity_irq_flag);
endmodule // prr_readout

// ---- prr_readout_tb.sv ----
// self-checking bench for the proximity result readout
`timescale 1ns/10ps
module prr_readout_tb;
  import prr_pkg::*;
  localparam logic [7:0] C_STAT = {1'b1, 2'h0, ADDR_STATUS};
  localparam logic [7:0] C_PAIR = {1'b1, TYPE_AUTO_INC, ADDR_RES_LOW};
  localparam logic [7:0] C_LOW  = {1'b1, 2'h0, ADDR_RES_LOW};
  localparam logic [7:0] C_HIGH = {1'b1, 2'h0, ADDR_RES_HIGH};
  localparam logic [7:0] C_CLR  = {1'b1, TYPE_SPECIAL, ADDR_CLR_IRQ};
  logic        clock, sys_rst, adc_done, sda_oe, sda_out, prox_irq;
  logic        scl, sda_low, between, nak;
  logic [15:0] adc_result;
  logic [7:0]  d0, d1;
  prr_cfg_s    cfg;
  wire         sda;
  int          errors, cmp_count;
  // pull-up wire: low when either party pulls it
  assign sda = ~(sda_oe | sda_low);
  always #12.5 clock = ~clock;
  prr_readout #(.DEV_ADDR(DEV_ADDR_DEF)) i_dut (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_adc_result(adc_result),
    .i_adc_done(adc_done), .i_cfg(cfg), .o_prox_irq(prox_irq));
  prr_host_model #(.ADDR(DEV_ADDR_DEF)) i_host (
    .i_clock(clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
    .o_between(between), .o_nak(nak));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle end-of-conversion pulse; irq is settled on return
  task automatic conv(input logic [15:0] res);
    @(posedge clock);
    #1;
    adc_result = res;
    adc_done = 1'b1;
    @(posedge clock);
    #1;
    adc_done = 1'b0;
  endtask
  task automatic t_status();
    cfg = '{8'h08, 8'h00, 8'h01, 8'h00, PERS_NONE};
    conv(16'h0050);
    chk({7'h00, prox_irq}, 8'h01);
    i_host.read_regs(C_STAT, 1'b0, d0, d1);
    chk(d0, 8'h20);
    i_host.write_cmd(C_STAT, 8'hff, 1'b1);
    i_host.read_regs(C_STAT, 1'b0, d0, d1);
    chk(d0, 8'h20);
    i_host.write_cmd(C_CLR, 8'h00, 1'b0);
    i_host.read_regs(C_STAT, 1'b0, d0, d1);
    chk(d0, 8'h00);
    $display("test status done");
  endtask
  // a new result lands between the two bytes of the pair read
  task automatic t_pair();
    conv(16'h1234);
    fork
      i_host.read_regs(C_PAIR, 1'b1, d0, d1);
      begin
        @(posedge between);
        conv(16'habcd);
      end
    join
    chk(d0, 8'h34);
    chk(d1, 8'h12);
    i_host.read_regs(C_HIGH, 1'b0, d0, d1);
    chk(d0, 8'h12);
    i_host.read_regs(C_LOW, 1'b0, d0, d1);
    chk(d0, 8'hcd);
    i_host.read_regs(C_HIGH, 1'b0, d0, d1);
    chk(d0, 8'hab);
    $display("test pair done");
  endtask
  // threshold edges and consecutive counting
  task automatic t_pers();
    i_host.write_cmd(C_CLR, 8'h00, 1'b0);
    cfg.interrupt_persistence_count = 4'h1;
    conv(16'h0100);
    conv(16'h0800);
    chk({7'h00, prox_irq}, 8'h00);
    conv(16'h0801);
    chk({7'h00, prox_irq}, 8'h01);
    i_host.write_cmd(C_CLR, 8'h00, 1'b0);
    conv(16'h00ff);
    chk({7'h00, prox_irq}, 8'h01);
    i_host.write_cmd(C_CLR, 8'h00, 1'b0);
    cfg.interrupt_persistence_count = 4'h2;
    conv(16'h0200);
    conv(16'h0010);
    conv(16'h0200);
    conv(16'h0900);
    chk({7'h00, prox_irq}, 8'h00);
    conv(16'h0010);
    chk({7'h00, prox_irq}, 8'h01);
    i_host.write_cmd(C_CLR, 8'h00, 1'b0);
    cfg.interrupt_persistence_count = PERS_NONE;
    conv(16'h0200);
    chk({7'h00, prox_irq}, 8'h01);
    chk({7'h00, nak}, 8'h00);
    chk({7'h00, sda_out}, 8'h00);
    $display("test persistence done");
  endtask
  task automatic close_out();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // runs take about 0.2 ms; a hang is cut at 1 ms
  initial
  begin
    #1000000;
    errors++;
    close_out();
  end
  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    adc_done = 1'b0;
    adc_result = 16'h0000;
    cfg = '0;
    repeat (20) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    t_status();
    t_pair();
    t_pers();
    close_out();
  end
endmodule // prr_readout_tb
